/* hw/slc_pkg.sv */
/*
 Constants, register map and types of the synthesizer loop configuration and lock detect block.
 Assumes a 20 MHz system clock and phase detector offsets measured in half-nanosecond units.
*/
package slc_pkg;
   localparam int CLK_HZ = 20_000_000;
   // register byte offsets
   localparam logic [3:0] REG_CONFIG = 4'h0;
   localparam logic [3:0] REG_FRAC_NUM = 4'h4;
   localparam logic [3:0] REG_FRAC_DEN = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hC;
   // config field positions
   localparam int CF_POLARITY = 0;
   localparam int CF_DOUBLER = 1;
   localparam int CF_WIDE = 2;
   localparam int CF_ORDER = 3;
   localparam int CF_DITHER = 6;
   localparam int CF_FLOAT = 8;
   localparam int CF_WINDOW = 9;
   localparam int CF_PINFN = 12;
   // config reset value: wide fraction on, window code 0, dither off
   localparam logic [15:0] CONFIG_RESET = 16'h00C4;
   localparam int FRAC_W = 22;
   localparam int NARROW_W = 10;
   localparam logic [2:0] ORDER_INT = 3'h0;
   localparam logic [2:0] ORDER_FIRST = 3'h1;
   localparam logic [2:0] ORDER_MAX = 3'h4;
   localparam logic [1:0] DITHER_OFF = 2'h3;
   localparam logic [3:0] PIN_LOCK = 4'h3;
   localparam logic [3:0] PIN_LOCK_INV = 4'h4;
   localparam logic [3:0] PIN_HIGH = 4'h1;
   localparam logic [3:0] PIN_LOW = 4'h2;
   localparam logic [2:0] LOCK_COUNT = 3'h5;
   localparam logic [2:0] WINDOW_MAX_CODE = 3'h5;
   // window base 3.5 ns and 2 ns step, in half-ns units
   localparam logic [7:0] WINDOW_BASE_HNS = 8'h07;
   localparam logic [7:0] WINDOW_STEP_HNS = 8'h04;
   // reference watchdog: no reference edge for this long means the reference stopped
   localparam int REF_TIMEOUT_NS = 2000;
   localparam int REF_TIMEOUT_CYC = (REF_TIMEOUT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [7:0] REF_TIMEOUT = 8'(REF_TIMEOUT_CYC);
   typedef enum logic {SLC_UNLOCKED, SLC_LOCKED} slc_lock_t;

   // window size in half-ns for a code; reserved codes take the largest window
   function automatic logic [7:0] window_hns(input logic [2:0] code);
      logic [2:0] c;
      c = (code > WINDOW_MAX_CODE) ? WINDOW_MAX_CODE : code;
      window_hns = WINDOW_BASE_HNS + 8'(WINDOW_STEP_HNS * c);
   endfunction : window_hns
endpackage : slc_pkg

/* hw/slc_lock_if.sv */
/*
 Carrier between the configuration top and the lock detector.
 Assumes both ends run on the same system clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface slc_lock_if;
   logic pd_cycle; // one comparison cycle finished
   logic [7:0] pd_offset; // R to N offset, half-ns
   logic [7:0] window; // selected window, half-ns
   logic ref_alive; // reference still toggling
   logic locked; // lock state
   logic [2:0] count; // consecutive in-window cycles
   modport det (input pd_cycle, pd_offset, window, ref_alive, output locked, count);
   modport ctl (output pd_cycle, pd_offset, window, ref_alive, input locked, count);
endinterface : slc_lock_if
`default_nettype wire

/* hw/slc_lock_detect.sv */
/*
 Digital lock detector: counts consecutive in-window comparison cycles and holds lock.
 Assumes comparison strobes and offsets are on the system clock.
*/
`timescale 1ns/100ps
`default_nettype none
module slc_lock_detect (
   input wire logic sys_clk_in, // system clock
   input wire logic nrst_in, // async reset, active low
   slc_lock_if.det lk // carrier
);
   slc_pkg::slc_lock_t state;
   slc_pkg::slc_lock_t next_state;
   logic [2:0] cnt;
   logic [2:0] next_cnt;

   // next lock state and run count
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      if (!lk.ref_alive) begin
         next_state = slc_pkg::SLC_UNLOCKED;
         next_cnt = 3'h0;
      end else if (lk.pd_cycle) begin
         if (lk.pd_offset < lk.window) begin
            if (cnt != slc_pkg::LOCK_COUNT) begin
               next_cnt = cnt + 3'h1;
            end
            if (cnt + 3'h1 >= slc_pkg::LOCK_COUNT) begin
               next_state = slc_pkg::SLC_LOCKED;
            end
         end else begin
            next_cnt = 3'h0;
            if (lk.pd_offset > lk.window) begin
               next_state = slc_pkg::SLC_UNLOCKED;
            end
         end
      end
   end

   // state registers
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state <= slc_pkg::SLC_UNLOCKED;
         cnt <= 3'h0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   assign lk.locked = (state == slc_pkg::SLC_LOCKED);
   assign lk.count = cnt;

   sequence s_in_win;
      lk.pd_cycle && lk.ref_alive && (lk.pd_offset < lk.window);
   endsequence
   property p_lock_needs_five;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      $rose(lk.locked) |-> $past(cnt) == 3'h4 && $past(lk.pd_cycle);
   endproperty
   a_lock_needs_five: assert property (p_lock_needs_five) else $error("lock without five cycles");
   property p_out_window_clears;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      (lk.pd_cycle && lk.pd_offset >= lk.window) |=> cnt == 3'h0;
   endproperty
   a_out_window_clears: assert property (p_out_window_clears) else $error("count not cleared");
   property p_dead_ref_unlocks;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      !lk.ref_alive |=> !lk.locked;
   endproperty
   a_dead_ref_unlocks: assert property (p_dead_ref_unlocks) else $error("stale lock");
   property p_hold_at_edge;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      (lk.locked && lk.ref_alive && lk.pd_cycle && lk.pd_offset == lk.window) |=> lk.locked;
   endproperty
   a_hold_at_edge: assert property (p_hold_at_edge) else $error("lock dropped at window");
   property p_five_lock;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      (cnt == 3'h4 && !lk.locked) ##0 s_in_win |=> lk.locked;
   endproperty
   a_five_lock: assert property (p_five_lock) else $error("fifth cycle did not lock");
endmodule : slc_lock_detect
`default_nettype wire

/* hw/slc_top.sv */
/*
 Synthesizer loop configuration registers on an Avalon-MM slave, decoded loop controls,
 lock detector and lock indicator pin driver.
 Assumes a 20 MHz clock, a time-to-digital front end delivering comparison strobes and
 offsets on this clock, and a reference input pin from outside this clock domain.
*/
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module slc_top (
   input wire logic sys_clk_in, // system clock, 20 MHz
   input wire logic nrst_in, // async reset, active low
   input wire logic [3:0] avs_address_in, // byte address
   input wire logic avs_read_in, // read request
   input wire logic avs_write_in, // write request
   input wire logic [31:0] avs_writedata_in, // write data
   input wire logic [3:0] avs_byteenable_in, // byte enables
   output logic [31:0] avs_readdata_out, // read data
   output logic avs_waitrequest_out, // wait request
   input wire logic reference_input_in, // reference pin, asynchronous
   input wire logic pd_cycle_in, // comparison cycle done pulse
   input wire logic [7:0] pd_offset_in, // R to N offset, half-ns
   output logic phase_polarity_out, // 1 positive, 0 negative
   output logic ref_doubler_out, // reference doubler on
   output logic r_div_bypass_out, // R divider bypassed
   output logic [21:0] frac_num_out, // effective numerator
   output logic [21:0] frac_den_out, // effective denominator
   output logic mod_enable_out, // delta-sigma modulator running
   output logic [2:0] mod_order_out, // effective order, 0 in integer mode
   output logic analog_comp_out, // analog compensation on
   output logic [1:0] dither_level_out, // effective dither strength
   output logic n_range_wide_out, // larger N counter range allowed
   output logic pump_float_out, // charge pump high impedance
   output logic lock_indicator_pin_out, // lock indicator pin level
   output logic lock_indicator_pin_oe_out // lock indicator pin enable
);
   logic [15:0] cfg;
   logic [15:0] next_cfg;
   logic [21:0] num;
   logic [21:0] next_num;
   logic [21:0] den;
   logic [21:0] next_den;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic wait_q;
   logic next_wait;
   logic [2:0] ref_sync;
   logic [7:0] ref_timer;
   logic [7:0] next_ref_timer;
   logic ref_alive;
   logic next_ref_alive;
   logic pol_q, dbl_q, byp_q, mod_en_q, comp_q, nwide_q, float_q, pin_q, pin_oe_q;
   logic next_pol, next_dbl, next_byp, next_mod_en, next_comp, next_nwide, next_float;
   logic next_pin, next_pin_oe;
   logic [21:0] num_q, den_q, next_num_o, next_den_o;
   logic [2:0] order_q, next_order_o;
   logic [1:0] dither_strength_q, next_dither_strength_o;
   logic [2:0] order_f;
   logic [1:0] dither_strength_f;
   logic [3:0] pinfn_f;
   logic order_bad;
   logic commit;
   logic [31:0] wr_word;

   slc_lock_if lk ();

   // byte-lane merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      merge = r;
   endfunction : merge

   assign order_f = cfg[slc_pkg::CF_ORDER +: 3];
   assign dither_strength_f = cfg[slc_pkg::CF_DITHER +: 2];
   assign pinfn_f = cfg[slc_pkg::CF_PINFN +: 4];
   assign order_bad = order_f > slc_pkg::ORDER_MAX;
   // a write takes effect at the edge where waitrequest is seen low
   assign commit = avs_write_in && !wait_q;

   // register file and bus answer
   always_comb begin
      next_cfg = cfg;
      next_num = num;
      next_den = den;
      next_rdata = rdata;
      next_wait = 1'b1;
      wr_word = 32'h0000_0000;
      if ((avs_read_in || avs_write_in) && wait_q) begin
         next_wait = 1'b0;
         next_rdata = 32'h0000_0000;
         if (avs_read_in) begin
            unique case (avs_address_in)
               slc_pkg::REG_CONFIG: next_rdata = {16'h0000, cfg};
               slc_pkg::REG_FRAC_NUM: next_rdata = {10'h000, num};
               slc_pkg::REG_FRAC_DEN: next_rdata = {10'h000, den};
               slc_pkg::REG_STATUS: next_rdata = {25'h000_0000, lk.count, 1'b0,
                                                 order_bad, ref_alive, lk.locked};
               default: next_rdata = 32'h0000_0000;
            endcase
         end
      end
      if (commit) begin
         unique case (avs_address_in)
            slc_pkg::REG_CONFIG: begin
               wr_word = merge({16'h0000, cfg}, avs_writedata_in, avs_byteenable_in);
               next_cfg = wr_word[15:0];
            end
            slc_pkg::REG_FRAC_NUM: begin
               wr_word = merge({10'h000, num}, avs_writedata_in, avs_byteenable_in);
               next_num = wr_word[21:0];
            end
            slc_pkg::REG_FRAC_DEN: begin
               wr_word = merge({10'h000, den}, avs_writedata_in, avs_byteenable_in);
               next_den = wr_word[21:0];
            end
            default: next_cfg = cfg;
         endcase
      end
   end

   // register file flops
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cfg <= slc_pkg::CONFIG_RESET;
         num <= 22'h00_0000;
         den <= 22'h00_0000;
         rdata <= 32'h0000_0000;
         wait_q <= 1'b1;
      end else begin
         cfg <= next_cfg;
         num <= next_num;
         den <= next_den;
         rdata <= next_rdata;
         wait_q <= next_wait;
      end
   end

   // reference watchdog: a stopped reference drops the alive flag
   always_comb begin
      next_ref_timer = ref_timer;
      next_ref_alive = ref_alive;
      if (ref_sync[2] != ref_sync[1]) begin
         next_ref_timer = 8'h00;
         next_ref_alive = 1'b1;
      end else if (ref_timer >= slc_pkg::REF_TIMEOUT - 8'h01) begin
         next_ref_alive = 1'b0;
      end else begin
         next_ref_timer = ref_timer + 8'h01;
      end
   end

   // reference synchroniser and watchdog flops
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ref_sync <= 3'h0;
         ref_timer <= 8'h00;
         ref_alive <= 1'b0;
      end else begin
         ref_sync <= {ref_sync[1:0], reference_input_in};
         ref_timer <= next_ref_timer;
         ref_alive <= next_ref_alive;
      end
   end

   // lock detector hookup
   assign lk.pd_cycle = pd_cycle_in;
   assign lk.pd_offset = pd_offset_in;
   assign lk.window = slc_pkg::window_hns(cfg[slc_pkg::CF_WINDOW +: 3]);
   assign lk.ref_alive = ref_alive;

   slc_lock_detect u_lock (
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .lk(lk)
   );

   // decoded loop controls
   always_comb begin
      next_pol = cfg[slc_pkg::CF_POLARITY];
      next_dbl = cfg[slc_pkg::CF_DOUBLER];
      next_byp = cfg[slc_pkg::CF_DOUBLER];
      next_float = cfg[slc_pkg::CF_FLOAT];
      if (cfg[slc_pkg::CF_WIDE]) begin
         next_num_o = num;
         next_den_o = den;
      end else begin
         next_num_o = {12'h000, num[slc_pkg::NARROW_W-1:0]};
         next_den_o = {12'h000, den[slc_pkg::NARROW_W-1:0]};
      end
      next_mod_en = !order_bad && order_f != slc_pkg::ORDER_INT;
      next_order_o = next_mod_en ? order_f : slc_pkg::ORDER_INT;
      next_comp = next_mod_en && order_f != slc_pkg::ORDER_FIRST;
      next_dither_strength_o = next_comp ? dither_strength_f : slc_pkg::DITHER_OFF;
      next_nwide = order_f == slc_pkg::ORDER_INT;
      next_pin = 1'b0;
      next_pin_oe = 1'b0;
      if (pinfn_f == slc_pkg::PIN_LOCK) begin
         next_pin = lk.locked;
         next_pin_oe = 1'b1;
      end else if (pinfn_f == slc_pkg::PIN_LOCK_INV) begin
         next_pin = !lk.locked;
         next_pin_oe = 1'b1;
      end else if (pinfn_f == slc_pkg::PIN_HIGH) begin
         next_pin = 1'b1;
         next_pin_oe = 1'b1;
      end else if (pinfn_f == slc_pkg::PIN_LOW) begin
         next_pin_oe = 1'b1;
      end
   end

   // output flops
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pol_q <= 1'b0;
         dbl_q <= 1'b0;
         byp_q <= 1'b0;
         float_q <= 1'b0;
         num_q <= 22'h00_0000;
         den_q <= 22'h00_0000;
         mod_en_q <= 1'b0;
         order_q <= 3'h0;
         comp_q <= 1'b0;
         dither_strength_q <= slc_pkg::DITHER_OFF;
         nwide_q <= 1'b1;
         pin_q <= 1'b0;
         pin_oe_q <= 1'b0;
      end else begin
         pol_q <= next_pol;
         dbl_q <= next_dbl;
         byp_q <= next_byp;
         float_q <= next_float;
         num_q <= next_num_o;
         den_q <= next_den_o;
         mod_en_q <= next_mod_en;
         order_q <= next_order_o;
         comp_q <= next_comp;
         dither_strength_q <= next_dither_strength_o;
         nwide_q <= next_nwide;
         pin_q <= next_pin;
         pin_oe_q <= next_pin_oe;
      end
   end

   assign avs_readdata_out = rdata;
   assign avs_waitrequest_out = wait_q;
   assign phase_polarity_out = pol_q;
   assign ref_doubler_out = dbl_q;
   assign r_div_bypass_out = byp_q;
   assign pump_float_out = float_q;
   assign frac_num_out = num_q;
   assign frac_den_out = den_q;
   assign mod_enable_out = mod_en_q;
   assign mod_order_out = order_q;
   assign analog_comp_out = comp_q;
   assign dither_level_out = dither_strength_q;
   assign n_range_wide_out = nwide_q;
   assign lock_indicator_pin_out = pin_q;
   assign lock_indicator_pin_oe_out = pin_oe_q;

   property p_polarity;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      ##1 phase_polarity_out == $past(cfg[slc_pkg::CF_POLARITY]);
   endproperty
   a_polarity: assert property (p_polarity) else $error("polarity mismatch");
   property p_bypass;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      ref_doubler_out == r_div_bypass_out;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass not tied to doubler");
   property p_narrow;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      !cfg[slc_pkg::CF_WIDE] |=> frac_num_out[21:10] == 12'h000 && frac_den_out[21:10] == 12'h000;
   endproperty
   a_narrow: assert property (p_narrow) else $error("high fraction bits used");
   property p_first_order;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      mod_order_out == slc_pkg::ORDER_FIRST |-> !analog_comp_out && dither_level_out == slc_pkg::DITHER_OFF;
   endproperty
   a_first_order: assert property (p_first_order) else $error("first order compensated");
   property p_illegal_order;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      order_bad |=> !mod_enable_out;
   endproperty
   a_illegal_order: assert property (p_illegal_order) else $error("illegal order ran");
   property p_float;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      $rose(cfg[slc_pkg::CF_FLOAT]) |=> pump_float_out;
   endproperty
   a_float: assert property (p_float) else $error("pump not floated");
   sequence s_pin_lock;
      pinfn_f == slc_pkg::PIN_LOCK ##1 pinfn_f == slc_pkg::PIN_LOCK;
   endsequence
   property p_pin_lock;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      s_pin_lock |-> lock_indicator_pin_out == $past(lk.locked) && lock_indicator_pin_oe_out;
   endproperty
   a_pin_lock: assert property (p_pin_lock) else $error("pin not showing lock");
   property p_ref_dead;
      @(posedge sys_clk_in) disable iff (!nrst_in)
      $fell(ref_alive) |-> ##[1:2] !lk.locked;
   endproperty
   a_ref_dead: assert property (p_ref_dead) else $error("lock kept on dead reference");
endmodule : slc_top
`default_nettype wire

/* sim/slc_host_model.sv */
/*
 Host controller model: Avalon-MM master that programs the loop configuration registers.
 Assumes the slave answers within 20 cycles by dropping waitrequest for one cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module slc_host_model (
   input wire logic sys_clk_in, // system clock
   input wire logic avs_waitrequest_in, // slave wait request
   input wire logic [31:0] avs_readdata_in, // slave read data
   output logic [3:0] avs_address_out, // byte address
   output logic avs_read_out, // read request
   output logic avs_write_out, // write request
   output logic [31:0] avs_writedata_out, // write data
   output logic [3:0] avs_byteenable_out // byte enables
);
   // bus idle at time zero
   initial begin
      avs_address_out = 4'h0;
      avs_read_out = 1'b0;
      avs_write_out = 1'b0;
      avs_writedata_out = 32'h0000_0000;
      avs_byteenable_out = 4'h0;
   end

   // one access: raised after an edge, held until waitrequest is sampled low
   task automatic access(input logic wr, input logic [3:0] addr, input logic [31:0] wdata,
                         output logic [31:0] rdata, output bit ok);
      int n;
      ok = 1'b0;
      rdata = 32'h0000_0000;
      @(posedge sys_clk_in);
      avs_address_out <= addr;
      avs_write_out <= wr;
      avs_read_out <= !wr;
      avs_writedata_out <= wdata;
      avs_byteenable_out <= 4'hF;
      for (n = 0; n < 20 && !ok; n++) begin
         @(posedge sys_clk_in);
         if (avs_waitrequest_in === 1'b0) begin
            ok = 1'b1;
            rdata = avs_readdata_in;
         end
      end
      avs_read_out <= 1'b0;
      avs_write_out <= 1'b0;
   endtask : access

   // config word as a careful controller writes it; no FSK is used, so wide mode stays free
   function automatic logic [15:0] cfg_word(input logic [15:0] raw, input logic [21:0] num);
      logic [15:0] c;
      c = raw;
      if (c[5:3] <= 3'h1) c[7:6] = 2'h3;
      if (c[5:3] >= 3'h2 && num == 22'h0) c[7:6] = 2'h3;
      cfg_word = c;
   endfunction : cfg_word
endmodule : slc_host_model
`default_nettype wire

/* sim/testbench.sv */
/*
 Self-checking bench of the loop configuration and lock detect block.
 Assumes the host model as bus master and a 20 MHz clock; comparison pulses at most every 2 cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic sys_clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic reference_input_in = 1'b0;
   logic pd_cycle_in = 1'b0;
   logic [7:0] pd_offset_in = 8'h00;
   logic ref_run = 1'b1;
   logic [1:0] ref_cnt = 2'h0;
   logic [3:0] avs_address, avs_byteenable;
   logic avs_read, avs_write, avs_waitrequest;
   logic [31:0] avs_writedata, avs_readdata;
   logic pol, dbl, byp, mod_en, ac, nwide, pflt, pin, pin_oe;
   logic [21:0] num_o, den_o;
   logic [2:0] ord_o;
   logic [1:0] dither_strength_o;
   int mismatches = 0;
   int n_tests = 0;

   slc_host_model u_slc_host_model (.sys_clk_in(sys_clk_in), .avs_waitrequest_in(avs_waitrequest),
      .avs_readdata_in(avs_readdata), .avs_address_out(avs_address), .avs_read_out(avs_read),
      .avs_write_out(avs_write), .avs_writedata_out(avs_writedata), .avs_byteenable_out(avs_byteenable));
   slc_top u_slc_top (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .avs_address_in(avs_address),
      .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
      .avs_byteenable_in(avs_byteenable), .avs_readdata_out(avs_readdata), .avs_waitrequest_out(avs_waitrequest),
      .reference_input_in(reference_input_in), .pd_cycle_in(pd_cycle_in), .pd_offset_in(pd_offset_in),
      .phase_polarity_out(pol), .ref_doubler_out(dbl), .r_div_bypass_out(byp), .frac_num_out(num_o),
      .frac_den_out(den_o), .mod_enable_out(mod_en), .mod_order_out(ord_o), .analog_comp_out(ac),
      .dither_level_out(dither_strength_o), .n_range_wide_out(nwide), .pump_float_out(pflt),
      .lock_indicator_pin_out(pin), .lock_indicator_pin_oe_out(pin_oe));

   // system clock, 50 ns period
   always #25 sys_clk_in = !sys_clk_in;

   // reference pin toggles every 4 cycles while running, stands still when stopped
   always @(posedge sys_clk_in) begin
      ref_cnt <= ref_cnt + 2'h1;
      if (ref_run && ref_cnt == 2'h3) reference_input_in <= !reference_input_in;
   end

   // expected control outputs for a config word with the lock state low
   function automatic logic [57:0] exp_outs(input logic [15:0] c, input logic [21:0] num, input logic [21:0] den);
      logic [2:0] o;
      logic en;
      logic [1:0] pv;
      o = c[5:3];
      en = (o >= 3'h1) && (o <= 3'h4);
      case (c[15:12])
         4'h1, 4'h4: pv = 2'h3;
         4'h2, 4'h3: pv = 2'h1;
         default: pv = 2'h0;
      endcase
      exp_outs = {c[0], c[1], c[1], c[2] ? num : {12'h000, num[9:0]}, c[2] ? den : {12'h000, den[9:0]},
                  en, en ? o : 3'h0, en && o != 3'h1, (en && o != 3'h1) ? c[7:6] : 2'h3, o == 3'h0, c[8], pv};
   endfunction : exp_outs

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      bit ok;
      u_slc_host_model.access(w, a, d, r, ok);
      if (!ok) begin
         mismatches++;
         print_verdict();
      end
   endtask : acc

   // comparison pulses with one offset, then settle until the pin reflects the decision
   task automatic pulse(input logic [7:0] off, input int n);
      repeat (n) begin
         @(posedge sys_clk_in);
         pd_cycle_in <= 1'b1;
         pd_offset_in <= off;
         @(posedge sys_clk_in);
         pd_cycle_in <= 1'b0;
      end
      repeat (2) @(posedge sys_clk_in);
      #1;
   endtask : pulse

   task automatic pin_is(input logic v);
      chk(64'({pin, pin_oe}), 64'({v, 1'b1}));
   endtask : pin_is

   // main sequence: reset, random config sweep, lock windows, reference loss
   initial begin
      logic [31:0] r;
      logic [15:0] c;
      logic [21:0] num, den;
      logic [7:0] w;
      void'($urandom(87941));
      repeat (3) @(posedge sys_clk_in);
      nrst_in <= 1'b1;
      acc(1'b0, slc_pkg::REG_CONFIG, 32'h0, r); chk(64'(r), 64'h0000_00C4);
      chk(64'({pol, dbl, byp, num_o, den_o, mod_en, ord_o, ac, dither_strength_o, nwide, pflt, pin, pin_oe}),
          64'(exp_outs(16'h00C4, 22'h0, 22'h0)));
      for (int i = 0; i < 24; i++) begin
         num = 22'($urandom);
         den = 22'($urandom);
         c = u_slc_host_model.cfg_word({4'($urandom), 3'($urandom), 1'($urandom), 2'($urandom), 3'(i),
                                        3'($urandom)}, num);
         acc(1'b1, slc_pkg::REG_FRAC_NUM, {10'h000, num}, r);
         acc(1'b1, slc_pkg::REG_FRAC_DEN, {10'h000, den}, r);
         acc(1'b1, slc_pkg::REG_CONFIG, {16'h0000, c}, r);
         repeat (2) @(posedge sys_clk_in);
         #1;
         chk(64'({pol, dbl, byp, num_o, den_o, mod_en, ord_o, ac, dither_strength_o, nwide, pflt, pin, pin_oe}),
             64'(exp_outs(c, num, den)));
         acc(1'b0, slc_pkg::REG_STATUS, 32'h0, r); chk(64'(r[2]), 64'(c[5:3] > 3'h4));
      end
      acc(1'b1, slc_pkg::REG_STATUS, 32'hFFFF_FFFF, r);
      acc(1'b0, slc_pkg::REG_CONFIG, 32'h0, r); chk(64'(r), 64'({16'h0000, c})); // status write ignored
      acc(1'b0, 4'h2, 32'h0, r); chk(64'(r), 64'h0);
      // every window code: boundary offsets for lock, count clear and unlock
      for (int k = 0; k < 8; k++) begin
         w = 8'(7 + 4 * ((k > 5) ? 5 : k));
         acc(1'b1, slc_pkg::REG_CONFIG, 32'h0000_30C4 | 32'(k << 9), r);
         pulse(w - 8'h01, 4);
         pulse(w, 1);
         acc(1'b0, slc_pkg::REG_STATUS, 32'h0, r); chk(64'(r & 32'h0000_0073), 64'h2);
         pulse(w - 8'h01, 4); pin_is(1'b0);
         pulse(8'h00, 1); pin_is(1'b1);
         pulse(w, 1); pin_is(1'b1);
         pulse(w + 8'h01, 1); pin_is(1'b0);
      end
      pulse(8'h00, 5); pin_is(1'b1);
      acc(1'b1, slc_pkg::REG_CONFIG, 32'h0000_40C4, r);
      repeat (2) @(posedge sys_clk_in);
      #1;
      pin_is(1'b0);
      @(posedge sys_clk_in);
      ref_run <= 1'b0;
      repeat (60) @(posedge sys_clk_in);
      #1;
      pin_is(1'b1);
      pulse(8'h00, 5); pin_is(1'b1);
      acc(1'b0, slc_pkg::REG_STATUS, 32'h0, r); chk(64'(r & 32'h0000_0003), 64'h0);
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
